// File: tb/temp_host_model.sv
// Host processor model driving the register port of the readout block
`include "temp_readout_defs.svh"

module temp_host_model (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_addr    = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data is scrambled once taken, so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge clock);
    reg_wr_en   <= 1'b0;
    reg_wr_data <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rd_data;
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // Both halves per result; the fraction always adds upward
  task automatic read_temp(output int t, output logic [7:0] hi,
                           output logic [7:0] lo);
    rd(`REG_TEMP_WHOLE, hi);
    rd(`REG_TEMP_SIXTEENTHS, lo);
    t = $signed(hi) * 16 + int'(lo[3:0]);
  endtask : read_temp
endmodule : temp_host_model

// File: tb/temp_readout_and_rate_limits_tb.sv
// Self-checking bench of the temperature readout and rate limit block
`include "temp_readout_defs.svh"

module temp_readout_and_rate_limits_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CONV = `TEMP_CONV_CYCLES;

  logic        clock        = 1'b0;
  logic        srst         = 1'b1;
  logic        sample_valid = 1'b0;
  logic [15:0] sample_ir    = 16'h0000;
  logic [15:0] sample_red   = 16'h0000;
  logic [11:0] die_temp     = 12'h000;
  logic [7:0]  reg_addr;
  logic        reg_wr_en;
  logic [7:0]  reg_wr_data;
  logic        reg_rd_en;
  logic [7:0]  reg_rd_data;
  logic        int_o;
  logic        int_oe_n;
  logic        ir_emitter_en;
  logic        red_emitter_en;
  logic [4:0]  adc_resolution;
  logic [2:0]  sample_rate_field;
  logic [1:0]  emitter_pulse_width_field;
  int          err_count    = 0;
  int          tests_run    = 0;
  int          cycles       = 0;
  logic [7:0]  rb;
  logic [31:0] rnd;
  logic [31:0] fifo_q[$];
  logic [7:0]  addrs[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06,
                             8'h07, 8'h16, 8'h17, 8'h20, 8'hFF};

  always #12.5 clock = ~clock;

  temp_host_model i_temp_host_model (
    .clock       (clock),
    .reg_addr    (reg_addr),
    .reg_wr_en   (reg_wr_en),
    .reg_wr_data (reg_wr_data),
    .reg_rd_en   (reg_rd_en),
    .reg_rd_data (reg_rd_data)
  );

  temp_readout_and_rate_limits i_temp_readout_and_rate_limits (
    .clock                     (clock),
    .srst                      (srst),
    .reg_addr                  (reg_addr),
    .reg_wr_en                 (reg_wr_en),
    .reg_wr_data               (reg_wr_data),
    .reg_rd_en                 (reg_rd_en),
    .reg_rd_data               (reg_rd_data),
    .sample_valid              (sample_valid),
    .sample_ir                 (sample_ir),
    .sample_red                (sample_red),
    .die_temp                  (die_temp),
    .int_o                     (int_o),
    .int_oe_n                  (int_oe_n),
    .ir_emitter_en             (ir_emitter_en),
    .red_emitter_en            (red_emitter_en),
    .adc_resolution            (adc_resolution),
    .sample_rate_field         (sample_rate_field),
    .emitter_pulse_width_field (emitter_pulse_width_field)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e,
                            input string m);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : check_byte

  task automatic check_num(input int g, input int e, input string m);
    tests_run++;
    if (g != e)
    begin
      err_count++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask : check_num

  ////////////////////////////////////////////////////////////////////////////
  // Highest rate code each pulse width tolerates
  function automatic int max_rate(input int pw, input bit hr);
    case (pw)
      0:       return 7;
      1:       return hr ? 7 : 4;
      2:       return 3;
      default: return 1;
    endcase
  endfunction : max_rate

  task automatic push(input logic [31:0] s);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_ir    <= s[31:16];
    sample_red   <= s[15:0];
    @(posedge clock);
    sample_valid <= 1'b0;
  endtask : push

  task automatic wait_pin(output int n);
    n = 0;
    while (int_oe_n !== 1'b0 && n < CONV + 100)
    begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : wait_pin

  // Conversion with the pin watched from the mode readback after the start write onward
  task automatic run_temp(input logic [11:0] dt);
    int         n;
    int         t;
    int         w;
    logic [7:0] hi;
    logic [7:0] lo;
    @(posedge clock);
    die_temp <= dt;
    i_temp_host_model.wr(`REG_INT_ENABLE, 8'h01);
    i_temp_host_model.wr(`REG_MODE_CFG, 8'h0B);
    i_temp_host_model.rd(`REG_MODE_CFG, rb);
    check_byte(rb, 8'h0B, "start bit held");
    check_byte({6'h00, int_o, int_oe_n}, 8'h01, "pin early");
    wait_pin(n);
    check_num(n + 3, CONV + 3, "pin delay");
    i_temp_host_model.rd(`REG_MODE_CFG, rb);
    check_byte(rb, 8'h03, "start bit clear");
    i_temp_host_model.read_temp(t, hi, lo);
    w = int'(dt[11:4]);
    if (w > 127)
      w = w - 256;
    check_byte(hi, dt[11:4], "whole degrees");
    check_byte(lo, {4'h0, dt[3:0]}, "sixteenths");
    check_num(t, w * 16 + int'(dt[3:0]), "combined");
    i_temp_host_model.rd(`REG_INT_STATUS, rb);
    check_byte(rb & 8'h01, 8'h01, "ready flag");
    repeat (2) @(posedge clock);
    #1;
    check_byte({7'h00, int_oe_n}, 8'h01, "pin released");
  endtask : run_temp

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(8560));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    foreach (addrs[i])
    begin
      i_temp_host_model.rd(addrs[i], rb);
      check_byte(rb, 8'h00, "reset value");
    end
    check_byte({3'h0, adc_resolution}, 8'h0D, "reset resolution");
    // Heart-rate and oximetry modes, every width and rate, bits 7:5 set at random
    for (int m = 2; m <= 3; m++)
    begin
      i_temp_host_model.wr(`REG_MODE_CFG, 8'(m));
      for (int pw = 0; pw < 4; pw++)
        for (int r = 0; r < 8; r++)
        begin
          int e;
          rnd = $urandom;
          e = max_rate(pw, m == 2);
          if (r < e)
            e = r;
          i_temp_host_model.wr(`REG_SAMPLE_CFG,
                               {rnd[7:5], 3'(r), 2'(pw)});
          i_temp_host_model.rd(`REG_SAMPLE_CFG, rb);
          check_byte(rb, {1'b0, rnd[6], 1'b0, 3'(e), 2'(pw)},
                     "cfg");
          check_byte({5'h00, sample_rate_field}, 8'(e), "rate");
          check_byte({6'h00, emitter_pulse_width_field}, 8'(pw), "pw");
          check_byte({3'h0, adc_resolution}, 8'(13 + pw), "res");
        end
      check_byte({6'h00, ir_emitter_en, red_emitter_en},
                 (m == 2) ? 8'h02 : 8'h03, "emitters");
    end
    rnd = $urandom;
    run_temp(rnd[11:0]);
    // Soft reset with start keeps results, clears the rest
    i_temp_host_model.wr(`REG_SAMPLE_CFG, 8'h07);
    i_temp_host_model.wr(`REG_MODE_CFG, 8'h4B);
    i_temp_host_model.rd(`REG_TEMP_WHOLE, rb);
    check_byte(rb, rnd[11:4], "kept whole");
    i_temp_host_model.rd(`REG_TEMP_SIXTEENTHS, rb);
    check_byte(rb, {4'h0, rnd[3:0]}, "kept sixteenths");
    i_temp_host_model.rd(`REG_SAMPLE_CFG, rb);
    check_byte(rb, 8'h00, "cfg reset");
    repeat (CONV + 10) @(posedge clock);
    i_temp_host_model.wr(`REG_MODE_CFG, 8'h40);
    i_temp_host_model.rd(`REG_TEMP_WHOLE, rb);
    check_byte(rb, 8'h00, "plain reset whole");
    rnd = $urandom;
    run_temp({8'h80, rnd[3:0]});
    // Fill past sixteen, then drain in byte order
    i_temp_host_model.wr(`REG_FIFO_WR_PTR, 8'h00);
    i_temp_host_model.wr(`REG_FIFO_RD_PTR, 8'h00);
    i_temp_host_model.wr(`REG_FIFO_OVF, 8'h00);
    i_temp_host_model.rd(`REG_INT_STATUS, rb);
    for (int i = 0; i < 17; i++)
    begin
      rnd = $urandom;
      push(rnd);
      if (i < 16)
        fifo_q.push_back(rnd);
      if (i == 14)
      begin
        i_temp_host_model.rd(`REG_INT_STATUS, rb);
        check_byte(rb & 8'h02, 8'h02, "almost full");
      end
    end
    i_temp_host_model.rd(`REG_FIFO_OVF, rb);
    check_byte(rb, 8'h01, "overflow");
    i_temp_host_model.rd(`REG_FIFO_WR_PTR, rb);
    check_byte(rb, 8'h00, "write pointer");
    while (fifo_q.size() > 0)
    begin
      rnd = fifo_q.pop_front();
      for (int b = 3; b >= 0; b--)
      begin
        i_temp_host_model.rd(`REG_FIFO_DATA, rb);
        check_byte(rb, rnd[b * 8 +: 8], "sample byte");
      end
    end
    i_temp_host_model.rd(`REG_FIFO_RD_PTR, rb);
    check_byte(rb, 8'h00, "read pointer");
    // Heart-rate mode stores red as zero; shutdown stores and flags nothing
    rnd = $urandom;
    i_temp_host_model.wr(`REG_MODE_CFG, 8'h02);
    push(rnd);
    for (int b = 3; b >= 0; b--)
    begin
      i_temp_host_model.rd(`REG_FIFO_DATA, rb);
      check_byte(rb, (b > 1) ? rnd[b * 8 +: 8] : 8'h00, "hr byte");
    end
    i_temp_host_model.wr(`REG_MODE_CFG, 8'h82);
    push(rnd);
    i_temp_host_model.rd(`REG_FIFO_WR_PTR, rb);
    check_byte(rb, 8'h01, "shutdown store");
    i_temp_host_model.rd(`REG_INT_STATUS, rb);
    check_byte(rb, 8'h00, "shutdown flags");
    check_byte({6'h00, ir_emitter_en, red_emitter_en}, 8'h00,
               "emitters off");
    give_verdict();
  end
endmodule : temp_readout_and_rate_limits_tb

// File: verilog/temp_conv.sv
// Single-shot die temperature conversion sequencer
`include "temp_readout_defs.svh"

module temp_conv (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [11:0] die_temp,
  temp_if.conv             tif
);
  localparam logic [11:0] LAST = 12'(`TEMP_CONV_CYCLES - 1);

  temp_readout_pkg::conv_state_e state_q;
  temp_readout_pkg::conv_state_e state_d;
  logic [11:0] cnt_q;
  logic [7:0]  whole_q;
  logic [3:0]  frac_q;
  wire         run_end = (cnt_q == LAST);

  always_comb
  begin
    case (state_q)
      temp_readout_pkg::CONV_IDLE:
        state_d = tif.start ? temp_readout_pkg::CONV_RUN : state_q;
      temp_readout_pkg::CONV_RUN:
        state_d = run_end ? temp_readout_pkg::CONV_DONE : state_q;
      temp_readout_pkg::CONV_DONE:
        state_d = temp_readout_pkg::CONV_IDLE;
      default:
        state_d = temp_readout_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      state_q <= temp_readout_pkg::CONV_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clock)
  begin
    if (srst || state_q != temp_readout_pkg::CONV_RUN)
      cnt_q <= 12'h000;
    else
      cnt_q <= cnt_q + 12'h001;
  end

  // Both halves latched in one edge, from the same sensor word
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      whole_q <= 8'h00;
      frac_q  <= 4'h0;
    end
    else if (state_q == temp_readout_pkg::CONV_RUN && run_end)
    begin
      whole_q <= die_temp[11:4];
      frac_q  <= die_temp[3:0];
    end
  end

  assign tif.done  = (state_q == temp_readout_pkg::CONV_DONE);
  assign tif.whole = whole_q;
  assign tif.frac  = frac_q;

  a_conv_length: assert property (@(posedge clock) disable iff (srst)
    $rose(state_q == temp_readout_pkg::CONV_DONE) |-> $past(cnt_q) == LAST)
    else $error("conversion ended early");
endmodule : temp_conv

// File: verilog/temp_if.sv
// Handshake between register logic and the temperature converter
interface temp_if;
  logic       start;
  logic       done;
  logic [7:0] whole;
  logic [3:0] frac;

  modport conv (input start, output done, output whole, output frac);
  modport ctrl (output start, input done, input whole, input frac);
endinterface : temp_if

// File: verilog/temp_readout_and_rate_limits.sv
// Temperature result registers, rate limits, sample store and interrupt pin
`include "temp_readout_defs.svh"

module temp_readout_and_rate_limits (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rd_data,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_ir,
  input  wire logic [15:0] sample_red,
  input  wire logic [11:0] die_temp,
  output logic             int_o,
  output logic             int_oe_n,
  output logic             ir_emitter_en,
  output logic             red_emitter_en,
  output logic      [4:0]  adc_resolution,
  output logic      [2:0]  sample_rate_field,
  output logic      [1:0]  emitter_pulse_width_field
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] max_rate(input logic [1:0] pw,
                                          input logic       hr);
    case (pw)
      `PW_200: max_rate = `RATE_1000;
      `PW_400: max_rate = hr ? `RATE_1000 : `RATE_400;
      `PW_800: max_rate = `RATE_200;
      default: max_rate = `RATE_100;
    endcase
  endfunction : max_rate

  temp_if tif ();

  temp_conv u_conv (
    .clock    (clock),
    .srst     (srst),
    .die_temp (die_temp),
    .tif      (tif)
  );

  logic [7:0]  mode_q;
  logic [7:0]  cfg_q;
  logic [7:0]  whole_q;
  logic [7:0]  frac_q;
  logic [7:0]  status_q;
  logic [7:0]  int_en_q;
  logic [3:0]  wr_ptr_q;
  logic [3:0]  rd_ptr_q;
  logic [4:0]  fill_q;
  logic [3:0]  ovf_q;
  logic [1:0]  byte_sel_q;
  logic [7:0]  rd_data_q;
  logic        int_oe_n_q;
  logic        ir_en_q;
  logic        red_en_q;
  logic [4:0]  res_q;
  temp_readout_pkg::sample_s mem [`FIFO_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire       wr_mode   = reg_wr_en && reg_addr == `REG_MODE_CFG;
  wire       wr_cfg    = reg_wr_en && reg_addr == `REG_SAMPLE_CFG;
  wire       wr_whole  = reg_wr_en && reg_addr == `REG_TEMP_WHOLE;
  wire       wr_frac   = reg_wr_en && reg_addr == `REG_TEMP_SIXTEENTHS;
  wire       wr_int_en = reg_wr_en && reg_addr == `REG_INT_ENABLE;
  wire       wr_wptr   = reg_wr_en && reg_addr == `REG_FIFO_WR_PTR;
  wire       wr_rptr   = reg_wr_en && reg_addr == `REG_FIFO_RD_PTR;
  wire       wr_ovf    = reg_wr_en && reg_addr == `REG_FIFO_OVF;
  wire       rd_status = reg_rd_en && reg_addr == `REG_INT_STATUS;
  wire       rd_fifo   = reg_rd_en && reg_addr == `REG_FIFO_DATA;
  wire       soft_rst  = wr_mode && reg_wr_data[`MODE_RESET_BIT];
  wire       keep_temp = soft_rst && reg_wr_data[`MODE_TEMP_EN_BIT];
  wire       wipe_temp = soft_rst && !keep_temp;
  wire [2:0] mode_w    = mode_q[`MODE_LSB +: 3];
  wire       shdn      = mode_q[`MODE_SHDN_BIT];
  wire       is_hr     = mode_w == `MODE_HR_ONLY;
  wire       acquiring = (is_hr || mode_w == `MODE_OXIMETRY) && !shdn;
  wire       temp_busy = mode_q[`MODE_TEMP_EN_BIT];
  wire [1:0] pw_new    = reg_wr_data[`CFG_PW_LSB +: 2];
  wire [2:0] rate_req  = reg_wr_data[`CFG_RATE_LSB +: 3];
  wire [2:0] rate_max  = max_rate(pw_new, is_hr);
  wire [2:0] rate_ok   = (rate_req > rate_max) ? rate_max : rate_req;
  wire [1:0] pw_w      = cfg_q[`CFG_PW_LSB +: 2];
  wire [2:0] rate_w    = cfg_q[`CFG_RATE_LSB +: 3];

  // A second start while busy is ignored rather than restarting
  assign tif.start = wr_mode && reg_wr_data[`MODE_TEMP_EN_BIT]
                     && !temp_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and sample configuration
  wire temp_en_d = (wr_mode && reg_wr_data[`MODE_TEMP_EN_BIT])
                   || (temp_busy && !tif.done);

  always_ff @(posedge clock)
  begin
    if (srst)
      mode_q <= `REG_RESET_VALUE;
    else if (soft_rst)
      mode_q <= {4'h0, temp_en_d, 3'h0};
    else if (wr_mode)
      mode_q <= {reg_wr_data[7], 3'h0, temp_en_d, reg_wr_data[2:0]};
    else
      mode_q[`MODE_TEMP_EN_BIT] <= temp_en_d;
  end

  always_ff @(posedge clock)
  begin
    if (srst || soft_rst)
      cfg_q <= `REG_RESET_VALUE;
    else if (wr_cfg)
      cfg_q <= {1'b0, reg_wr_data[`CFG_HI_RES_BIT], 1'b0,
                rate_ok, pw_new};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature result; a conversion loads both halves together, a host write loads only its own half
  always_ff @(posedge clock)
  begin
    if (srst || wipe_temp)
    begin
      whole_q <= `REG_RESET_VALUE;
      frac_q  <= `REG_RESET_VALUE;
    end
    else if (tif.done)
    begin
      whole_q <= tif.whole;
      frac_q  <= {4'h0, tif.frac};
    end
    else
    begin
      if (wr_whole)
        whole_q <= reg_wr_data;
      if (wr_frac)
        frac_q <= {4'h0, reg_wr_data[3:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample store
  wire       full     = fill_q == `FIFO_FULL;
  wire       push     = sample_valid && acquiring && !full;
  wire       drop     = sample_valid && acquiring && full;
  wire       pop      = rd_fifo && fill_q != 5'h00 && byte_sel_q == `BYTE_LAST;
  wire       step     = rd_fifo && fill_q != 5'h00;
  wire [4:0] fill_nx  = fill_q + {4'h0, push} - {4'h0, pop};
  wire [3:0] wptr_nx  = wr_wptr ? reg_wr_data[3:0] : wr_ptr_q;
  wire [3:0] rptr_nx  = wr_rptr ? reg_wr_data[3:0] : rd_ptr_q;
  wire       ptr_wr   = wr_wptr || wr_rptr;
  // Host pointer writes cannot express a full store; it reads as empty
  wire [4:0] fill_set = {1'b0, wptr_nx - rptr_nx};
  wire       af_event = fill_nx == `FIFO_ALMOST_FULL
                        && fill_q != `FIFO_ALMOST_FULL;
  wire temp_readout_pkg::sample_s head = mem[rd_ptr_q];

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr_q] <= '{ir: sample_ir, red: is_hr ? 16'h0000 : sample_red};
  end

  always_ff @(posedge clock)
  begin
    if (srst || soft_rst)
    begin
      wr_ptr_q   <= 4'h0;
      rd_ptr_q   <= 4'h0;
      fill_q     <= 5'h00;
      byte_sel_q <= 2'h0;
    end
    else if (ptr_wr)
    begin
      wr_ptr_q   <= wptr_nx;
      rd_ptr_q   <= rptr_nx;
      fill_q     <= fill_set;
      byte_sel_q <= 2'h0;
    end
    else
    begin
      wr_ptr_q   <= wr_ptr_q + {3'h0, push};
      rd_ptr_q   <= rd_ptr_q + {3'h0, pop};
      fill_q     <= fill_nx;
      byte_sel_q <= byte_sel_q + {1'b0, step};
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst || soft_rst || wr_ovf)
      ovf_q <= 4'h0;
    else if (drop && ovf_q != `OVF_MAX)
      ovf_q <= ovf_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a new event wins over the read that clears; shutdown wipes all
  wire [7:0] events;
  assign events[`INT_TEMP_RDY_BIT]    = tif.done;
  assign events[`INT_ALMOST_FULL_BIT] = af_event && !ptr_wr;
  assign events[`INT_SAMPLE_RDY_BIT]  = push;
  assign events[7:3]                  = 5'h00;

  wire [7:0] status_d = shdn ? 8'h00
                             : ((rd_status ? 8'h00 : status_q) | events);
  wire       int_any  = |(status_q & int_en_q);

  always_ff @(posedge clock)
  begin
    if (srst || soft_rst)
      status_q <= `REG_RESET_VALUE;
    else
      status_q <= status_d;
  end

  always_ff @(posedge clock)
  begin
    if (srst || soft_rst)
      int_en_q <= `REG_RESET_VALUE;
    else if (wr_int_en)
      int_en_q <= {5'h00, reg_wr_data[2:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and registered outputs
  wire [7:0] fifo_byte = (byte_sel_q == 2'h0) ? head.ir[15:8]
                       : (byte_sel_q == 2'h1) ? head.ir[7:0]
                       : (byte_sel_q == 2'h2) ? head.red[15:8]
                       : head.red[7:0];
  wire [7:0] rd_mux =
      (reg_addr == `REG_INT_STATUS)      ? status_q
    : (reg_addr == `REG_INT_ENABLE)      ? int_en_q
    : (reg_addr == `REG_FIFO_WR_PTR)     ? {4'h0, wr_ptr_q}
    : (reg_addr == `REG_FIFO_OVF)        ? {4'h0, ovf_q}
    : (reg_addr == `REG_FIFO_RD_PTR)     ? {4'h0, rd_ptr_q}
    : (reg_addr == `REG_FIFO_DATA)       ? fifo_byte
    : (reg_addr == `REG_MODE_CFG)        ? mode_q
    : (reg_addr == `REG_SAMPLE_CFG)      ? cfg_q
    : (reg_addr == `REG_TEMP_WHOLE)      ? whole_q
    : (reg_addr == `REG_TEMP_SIXTEENTHS) ? frac_q
    : 8'h00;

  always_ff @(posedge clock)
  begin
    if (srst)
      rd_data_q <= `REG_RESET_VALUE;
    else if (reg_rd_en)
      rd_data_q <= rd_mux;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      int_oe_n_q <= 1'b1;
      ir_en_q    <= 1'b0;
      red_en_q   <= 1'b0;
      res_q      <= `RES_BASE_BITS;
    end
    else
    begin
      int_oe_n_q <= !int_any;
      ir_en_q    <= acquiring;
      red_en_q   <= acquiring && !is_hr;
      res_q      <= `RES_BASE_BITS + {3'h0, pw_w};
    end
  end

  assign reg_rd_data               = rd_data_q;
  assign int_o                     = 1'b0;
  assign int_oe_n                  = int_oe_n_q;
  assign ir_emitter_en             = ir_en_q;
  assign red_emitter_en            = red_en_q;
  assign adc_resolution            = res_q;
  assign sample_rate_field         = rate_w;
  assign emitter_pulse_width_field = pw_w;

  ////////////////////////////////////////////////////////////////////////////
  a_temp_pair_load: assert property (@(posedge clock) disable iff (srst)
    tif.done && !wipe_temp |=> whole_q == $past(tif.whole)
      && frac_q[3:0] == $past(tif.frac))
    else $error("temperature halves not loaded together");

  a_frac_upper_zero: assert property (@(posedge clock) disable iff (srst)
    reg_rd_en && reg_addr == `REG_TEMP_SIXTEENTHS |=>
      rd_data_q[7:4] == 4'h0)
    else $error("fraction upper bits not zero");

  a_rate_clamp: assert property (@(posedge clock) disable iff (srst)
    wr_cfg && !soft_rst |=> rate_w <= $past(rate_max))
    else $error("illegal rate stored");

  a_long_pulse_rate: assert property (@(posedge clock) disable iff (srst)
    pw_w == 2'h3 |-> rate_w <= `RATE_100)
    else $error("rate above 100 with longest pulse");

  a_red_off_hr: assert property (@(posedge clock) disable iff (srst)
    is_hr |=> !red_en_q)
    else $error("red emitter on in heart-rate mode");

  a_int_pin_level: assert property (@(posedge clock) disable iff (srst)
    ##1 int_oe_n_q == !$past(int_any))
    else $error("interrupt pin does not follow flags");

  a_temp_en_clear: assert property (@(posedge clock) disable iff (srst)
    tif.done && !wr_mode |=> !temp_busy ##1 !tif.done)
    else $error("start bit not cleared at conversion end");

  a_temp_ready_flag: assert property (@(posedge clock) disable iff (srst)
    tif.done && !shdn && !soft_rst |=>
      status_q[`INT_TEMP_RDY_BIT])
    else $error("temperature ready flag missing");

  a_store_bound: assert property (@(posedge clock) disable iff (srst)
    fill_q <= `FIFO_FULL)
    else $error("sample store over depth");

  a_soft_keep: assert property (@(posedge clock) disable iff (srst)
    keep_temp && !tif.done |=> whole_q == $past(whole_q)
      && frac_q == $past(frac_q))
    else $error("soft reset lost temperature");

  a_resolution: assert property (@(posedge clock) disable iff (srst)
    $stable(pw_w) |=> res_q == `RES_BASE_BITS + {3'h0, $past(pw_w)})
    else $error("resolution wrong for pulse width");
endmodule : temp_readout_and_rate_limits

// File: verilog/temp_readout_defs.svh
// Register offsets, field positions and timing counts of the readout block
`ifndef TEMP_READOUT_DEFS_SVH
`define TEMP_READOUT_DEFS_SVH
`define REG_INT_STATUS      8'h00
`define REG_INT_ENABLE      8'h01
`define REG_FIFO_WR_PTR     8'h02
`define REG_FIFO_OVF        8'h03
`define REG_FIFO_RD_PTR     8'h04
`define REG_FIFO_DATA       8'h05
`define REG_MODE_CFG        8'h06
`define REG_SAMPLE_CFG      8'h07
`define REG_TEMP_WHOLE      8'h16
`define REG_TEMP_SIXTEENTHS 8'h17
`define REG_RESET_VALUE     8'h00
`define MODE_SHDN_BIT       7
`define MODE_RESET_BIT      6
`define MODE_TEMP_EN_BIT    3
`define MODE_LSB            0
`define MODE_HR_ONLY        3'h2
`define MODE_OXIMETRY       3'h3
`define CFG_HI_RES_BIT      6
`define CFG_RATE_LSB        2
`define CFG_PW_LSB          0
`define INT_TEMP_RDY_BIT    0
`define INT_ALMOST_FULL_BIT 1
`define INT_SAMPLE_RDY_BIT  2
`define RATE_100            3'h1
`define RATE_200            3'h3
`define RATE_400            3'h4
`define RATE_1000           3'h7
`define PW_200              2'h0
`define PW_400              2'h1
`define PW_800              2'h2
`define RES_BASE_BITS       5'h0D
`define FIFO_DEPTH          16
`define FIFO_FULL           5'h10
`define FIFO_ALMOST_FULL    5'h0F
`define OVF_MAX             4'hF
`define BYTE_LAST           2'h3
`define CLOCK_PERIOD_NS     25
`define TEMP_CONV_NS        100000
`define TEMP_CONV_CYCLES \
  ((`TEMP_CONV_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// File: verilog/temp_readout_pkg.sv
// Types shared by the readout block
package temp_readout_pkg;
  typedef enum logic [2:0] {
    CONV_IDLE = 3'h1,
    CONV_RUN  = 3'h2,
    CONV_DONE = 3'h4
  } conv_state_e;

  typedef struct packed {
    logic [15:0] ir;
    logic [15:0] red;
  } sample_s;
endpackage : temp_readout_pkg
